// ### cbt_defines.svh
// Purpose: named constants of the context bank table controller
// Assumes: included by the package and by the bench
// Notes:   offsets are byte addresses on the register bus
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH

// table sizing
`define CBT_MAX_BANKS     8'h80
`define CBT_NUM_BANKS     8'h08
`define CBT_NUM_S2ONLY    8'h02
`define CBT_BANK_IW       3
`define CBT_NESTED        1'b1

// global register offsets
`define CBT_OFF_IDR1      32'h0000_0000
`define CBT_OFF_SCR1      32'h0000_0004
`define CBT_OFF_CTRL      32'h0000_0008
`define CBT_OFF_STAT      32'h0000_000c
`define CBT_OFF_IRQ_ST    32'h0000_0010
`define CBT_OFF_IRQ_MASK  32'h0000_0014

// bank table placement and word index inside a bank page
`define CBT_BANK_BASE     32'h0080_0000
`define CBT_BW_ATTR       10'h000
`define CBT_BW_ATTR2      10'h001
`define CBT_BW_SCHEME     10'h002

// field positions
`define CBT_IDR1_PS_BIT   31
`define CBT_IDR1_NEST_BIT 30
`define CBT_CTRL_TRANS    0
`define CBT_CTRL_TLB      1
`define CBT_CTRL_INV      2
`define CBT_CTRL_PS64     3
`define CBT_ATTR_HYPERVISOR_CONTEXT_BIT     8
`define CBT_ATTR2_WIDE    0
`define CBT_ATTR2_MONITOR_CONTEXT_BIT    1

// event bits of the interrupt status register
`define CBT_EV_CFG        0
`define CBT_EV_INVCTX     1
`define CBT_EV_EARLY      2

// bank type codes
`define CBT_TYPE_S2       2'h0
`define CBT_TYPE_S1_BYP   2'h1
`define CBT_TYPE_S1_FLT   2'h2
`define CBT_TYPE_S1_S2    2'h3

// bus responses
`define CBT_RESP_OKAY     2'h0
`define CBT_RESP_SLVERR   2'h2
`define CBT_RESP_DECERR   2'h3

`endif

// ### cbt_pkg.sv
// Purpose: shared types of the context bank table controller
// Assumes: cbt_defines.svh sits beside this file
// Notes:   all module state travels as one packed struct
`include "cbt_defines.svh"
package cbt_pkg;

    typedef struct packed {
        logic [1:0] btype;
        logic       hypervisor_context_bit;
        logic       wide;
        logic       monitor_context_bit;
    } cbt_bank_t;

    typedef struct packed {
        logic stage2;
        logic table_base_register_pair;
        logic invalid;
    } cbt_scheme_t;

    typedef struct packed {
        logic       glob;
        logic       fault;
        logic       decerr;
        logic [6:0] bank;
        logic [9:0] word;
    } cbt_dec_t;

    typedef struct packed {
        logic       valid;
        logic [6:0] bank;
        logic [6:0] bank2;
        logic       two;
        logic       translate;
        logic       tlb_use;
        logic       table_base_register_pair;
        logic       fault;
        logic       prefetch;
    } cbt_sel_t;

    typedef struct packed {
        logic        aw_full;
        logic [31:0] aw_addr;
        logic        aw_ns;
        logic        w_full;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [7:0]  nsalloc;
        logic        trans_en;
        logic        tlb_en;
        logic        page64;
        logic        inv_done;
        logic [2:0]  irq_st;
        logic [2:0]  irq_mask;
        logic        irq;
        cbt_bank_t [`CBT_NUM_BANKS-1:0] banks;
        cbt_sel_t    sel;
    } cbt_state_t;

endpackage

// ### cbt_scheme.sv
// Purpose: translation scheme of one bank from its attributes
// Assumes: secure means the bank sits above the non-secure allocation
// Notes:   purely combinational, used for the read path and for traffic
`timescale 1ns/1ps
module cbt_scheme
    import cbt_pkg::*;
(
    // bank attributes
    input  wire logic        secure,
    input  wire cbt_bank_t   attr,
    // decoded scheme
    output cbt_scheme_t      scheme
);

    always_comb
    begin
        scheme = '0;
        if (secure)
        begin
            // secure banks only run stage 1 with stage 2 bypass
            scheme.invalid = (attr.btype != `CBT_TYPE_S1_BYP);
            // wide monitor together with hypervisor has no defined meaning
            scheme.invalid = scheme.invalid |
                             (attr.wide & attr.hypervisor_context_bit & attr.monitor_context_bit);
            scheme.table_base_register_pair = ~attr.hypervisor_context_bit &
                               ~(attr.wide & attr.monitor_context_bit);
        end
        else
        begin
            scheme.stage2    = (attr.btype == `CBT_TYPE_S2);
            scheme.table_base_register_pair = ~scheme.stage2 & ~attr.hypervisor_context_bit;
        end
    end

endmodule // cbt_scheme

// ### cbt_top.sv
// Purpose: context bank table control with an AXI4-Lite register port
// Assumes: AxPROT[1] high marks a non-secure configuration access
// Notes:   the bank table starts at a fixed base, one page per bank
`timescale 1ns/1ps
module cbt_top
    import cbt_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // AXI4-Lite write address and data
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_AWADDR,
    input  wire logic [2:0]  S_AXI_AWPROT,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    // AXI4-Lite write response
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output logic [1:0]       S_AXI_BRESP,
    // AXI4-Lite read
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    input  wire logic [31:0] S_AXI_ARADDR,
    input  wire logic [2:0]  S_AXI_ARPROT,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    // bank selection from upstream traffic
    input  wire logic        TXN_VALID,
    input  wire logic [6:0]  TXN_BANK,
    input  wire logic        TXN_TWO_STAGE,
    input  wire logic [6:0]  TXN_BANK2,
    // selection result
    output logic             SEL_VALID,
    output logic [6:0]       SEL_BANK,
    output logic [6:0]       SEL_BANK2,
    output logic             SEL_TWO,
    output logic             SEL_TRANSLATE,
    output logic             SEL_TLB_USE,
    output logic             SEL_TABLE_BASE_REGISTER_PAIR,
    output logic             SEL_FAULT,
    output logic             PREFETCH_EN,
    // interrupt
    output logic             IRQ
);

    function automatic cbt_state_t rst_state();
        cbt_state_t s;
        s = '0;
        // every bank starts non-secure
        s.nsalloc = `CBT_NUM_BANKS;
        return s;
    endfunction

    localparam cbt_state_t ST_RST = rst_state();

    // global window below the table, bank pages above it
    function automatic cbt_dec_t decode(
        input logic [31:0] addr,
        input logic        ns,
        input logic [7:0]  nsalloc,
        input logic        page64
    );
        cbt_dec_t   d;
        logic [31:0] rel;
        d   = '0;
        rel = addr - `CBT_BANK_BASE;
        if (addr < `CBT_BANK_BASE)
        begin
            d.glob   = 1'b1;
            d.word   = addr[11:2];
            d.decerr = (addr > `CBT_OFF_IRQ_MASK);
        end
        else if (page64)
        begin
            d.bank   = rel[22:16];
            d.word   = {4'h0, rel[15:10]} == 10'h000 ?
                       rel[11:2] : 10'h3ff;
            d.decerr = (rel[31:23] != 9'h000);
        end
        else
        begin
            d.bank   = rel[18:12];
            d.word   = rel[11:2];
            d.decerr = (rel[31:19] != 13'h0000);
        end
        if (!d.glob && !d.decerr)
        begin
            // unimplemented banks and secure banks seen from non-secure
            d.fault = ({1'b0, d.bank} >= `CBT_NUM_BANKS) ||
                      (ns && ({1'b0, d.bank} >= nsalloc));
        end
        return d;
    endfunction

    cbt_state_t            st_r;
    cbt_state_t            st_nxt;
    cbt_dec_t              wd;
    cbt_dec_t              rd;
    cbt_scheme_t           rd_sch;
    cbt_scheme_t           tx_sch;
    logic [`CBT_BANK_IW-1:0] rd_idx;
    logic [`CBT_BANK_IW-1:0] wr_idx;
    logic [`CBT_BANK_IW-1:0] tx_idx;
    logic                  rd_sec;
    logic                  tx_sec;

    assign rd_idx = rd.bank[`CBT_BANK_IW-1:0];
    assign wr_idx = wd.bank[`CBT_BANK_IW-1:0];
    assign tx_idx = TXN_BANK[`CBT_BANK_IW-1:0];
    assign rd_sec = ({1'b0, rd.bank} >= st_r.nsalloc);
    assign tx_sec = ({1'b0, TXN_BANK} >= st_r.nsalloc);
    assign wd = decode(st_r.aw_addr, st_r.aw_ns, st_r.nsalloc, st_r.page64);
    assign rd = decode(S_AXI_ARADDR, S_AXI_ARPROT[1], st_r.nsalloc,
                       st_r.page64);

    cbt_scheme u_rd_scheme
    (
        .secure (rd_sec),
        .attr   (st_r.banks[rd_idx]),
        .scheme (rd_sch)
    );

    cbt_scheme u_tx_scheme
    (
        .secure (tx_sec),
        .attr   (st_r.banks[tx_idx]),
        .scheme (tx_sch)
    );

    always_comb
    begin
        logic [2:0]  ev;
        logic [7:0]  alloc;
        logic        bank_wr;
        logic [31:0] rv;
        ev      = '0;
        alloc   = '0;
        bank_wr = 1'b0;
        rv      = '0;
        st_nxt  = st_r;

        // write channels are taken independently, in either order
        if (S_AXI_AWVALID && st_r.awready)
        begin
            st_nxt.aw_full = 1'b1;
            st_nxt.aw_addr = S_AXI_AWADDR;
            st_nxt.aw_ns   = S_AXI_AWPROT[1];
        end
        if (S_AXI_WVALID && st_r.wready)
        begin
            st_nxt.w_full = 1'b1;
            st_nxt.wdata  = S_AXI_WDATA;
            st_nxt.wstrb  = S_AXI_WSTRB;
        end
        if (st_r.bvalid && S_AXI_BREADY)
            st_nxt.bvalid = 1'b0;

        if (st_r.aw_full && st_r.w_full && !st_r.bvalid)
        begin
            st_nxt.aw_full = 1'b0;
            st_nxt.w_full  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = `CBT_RESP_OKAY;
            if (wd.decerr)
                st_nxt.bresp = `CBT_RESP_DECERR;
            else if (wd.fault)
            begin
                st_nxt.bresp = `CBT_RESP_SLVERR;
                ev[`CBT_EV_CFG] = 1'b1;
            end
            else if (wd.glob)
            begin
                unique case (32'({wd.word, 2'b00}))
                    `CBT_OFF_SCR1:
                    begin
                        // non-secure writes to the allocation are ignored
                        if (!st_r.aw_ns && st_r.wstrb[0])
                        begin
                            alloc = st_r.wdata[7:0];
                            if (alloc > `CBT_NUM_BANKS)
                                alloc = `CBT_NUM_BANKS;
                            if (alloc < `CBT_NUM_S2ONLY)
                                alloc = `CBT_NUM_S2ONLY;
                            for (int i = 0; i < `CBT_NUM_BANKS; i++)
                            begin
                                // banks that flip security lose wide select
                                if ((8'(i) >= alloc) !=
                                    (8'(i) >= st_r.nsalloc))
                                    st_nxt.banks[i].wide = 1'b0;
                            end
                            st_nxt.nsalloc = alloc;
                        end
                    end
                    `CBT_OFF_CTRL:
                    begin
                        if (st_r.wstrb[0])
                        begin
                            st_nxt.trans_en = st_r.wdata[`CBT_CTRL_TRANS];
                            st_nxt.tlb_en   = st_r.wdata[`CBT_CTRL_TLB];
                            st_nxt.page64   = st_r.wdata[`CBT_CTRL_PS64];
                            if (st_r.wdata[`CBT_CTRL_INV])
                                st_nxt.inv_done = 1'b1;
                            // enabling a TLB that was never invalidated
                            if (st_nxt.tlb_en && !st_r.tlb_en &&
                                !st_nxt.inv_done)
                                ev[`CBT_EV_EARLY] = 1'b1;
                        end
                    end
                    `CBT_OFF_IRQ_ST:
                    begin
                        if (st_r.wstrb[0])
                            st_nxt.irq_st = st_r.irq_st & ~st_r.wdata[2:0];
                    end
                    `CBT_OFF_IRQ_MASK:
                    begin
                        if (st_r.wstrb[0])
                            st_nxt.irq_mask = st_r.wdata[2:0];
                    end
                    default:
                    begin
                    end
                endcase
            end
            else
            begin
                bank_wr = 1'b1;
                if (wd.word == `CBT_BW_ATTR)
                begin
                    // stage 2 only banks keep their fixed format
                    if (st_r.wstrb[0] &&
                        {1'b0, wd.bank} >= `CBT_NUM_S2ONLY)
                        st_nxt.banks[wr_idx].btype = st_r.wdata[1:0];
                    if (st_r.wstrb[1])
                        st_nxt.banks[wr_idx].hypervisor_context_bit =
                            st_r.wdata[`CBT_ATTR_HYPERVISOR_CONTEXT_BIT];
                end
                else if (wd.word == `CBT_BW_ATTR2 && st_r.wstrb[0])
                begin
                    st_nxt.banks[wr_idx].wide = st_r.wdata[`CBT_ATTR2_WIDE];
                    st_nxt.banks[wr_idx].monitor_context_bit = st_r.wdata[`CBT_ATTR2_MONITOR_CONTEXT_BIT];
                end
            end
        end
        st_nxt.awready = ~st_nxt.aw_full & ~st_nxt.bvalid;
        st_nxt.wready  = ~st_nxt.w_full & ~st_nxt.bvalid;

        // read: one outstanding, answered on the cycle after the address
        if (st_r.rvalid && S_AXI_RREADY)
            st_nxt.rvalid = 1'b0;
        if (S_AXI_ARVALID && st_r.arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = `CBT_RESP_OKAY;
            if (rd.decerr)
                st_nxt.rresp = `CBT_RESP_DECERR;
            else if (rd.fault)
            begin
                st_nxt.rresp = `CBT_RESP_SLVERR;
                ev[`CBT_EV_CFG] = 1'b1;
            end
            else if (rd.glob)
            begin
                unique case (32'({rd.word, 2'b00}))
                    `CBT_OFF_IDR1:
                    begin
                        rv[`CBT_IDR1_PS_BIT]   = st_r.page64;
                        rv[`CBT_IDR1_NEST_BIT] = `CBT_NESTED;
                        rv[23:16] = `CBT_NUM_S2ONLY;
                        // non-secure sees only its own share
                        rv[7:0] = S_AXI_ARPROT[1] ? st_r.nsalloc :
                                  `CBT_NUM_BANKS;
                    end
                    `CBT_OFF_SCR1:
                        rv[7:0] = S_AXI_ARPROT[1] ? 8'h00 : st_r.nsalloc;
                    `CBT_OFF_CTRL:
                    begin
                        rv[`CBT_CTRL_TRANS] = st_r.trans_en;
                        rv[`CBT_CTRL_TLB]   = st_r.tlb_en;
                        rv[`CBT_CTRL_PS64]  = st_r.page64;
                    end
                    `CBT_OFF_STAT:
                        rv[1:0] = {st_r.tlb_en & st_r.inv_done,
                                   st_r.inv_done};
                    `CBT_OFF_IRQ_ST:
                        rv[2:0] = st_r.irq_st;
                    `CBT_OFF_IRQ_MASK:
                        rv[2:0] = st_r.irq_mask;
                    default:
                    begin
                    end
                endcase
            end
            else if (rd.word == `CBT_BW_ATTR)
            begin
                rv[1:0] = st_r.banks[rd_idx].btype;
                rv[`CBT_ATTR_HYPERVISOR_CONTEXT_BIT] = st_r.banks[rd_idx].hypervisor_context_bit;
            end
            else if (rd.word == `CBT_BW_ATTR2)
            begin
                rv[`CBT_ATTR2_WIDE] = st_r.banks[rd_idx].wide;
                rv[`CBT_ATTR2_MONITOR_CONTEXT_BIT] = st_r.banks[rd_idx].monitor_context_bit;
            end
            else if (rd.word == `CBT_BW_SCHEME)
                rv[3:0] = {rd_sec, rd_sch};
            st_nxt.rdata = rv;
        end
        st_nxt.arready = ~st_nxt.rvalid;

        // bank selection for upstream traffic, one result per request
        st_nxt.sel = '0;
        if (TXN_VALID)
        begin
            st_nxt.sel.valid = 1'b1;
            st_nxt.sel.bank  = TXN_BANK;
            // a second bank only exists with nested support
            st_nxt.sel.two   = TXN_TWO_STAGE & `CBT_NESTED;
            st_nxt.sel.bank2 = st_nxt.sel.two ? TXN_BANK2 : 7'h00;
            st_nxt.sel.fault = ({1'b0, TXN_BANK} >= `CBT_NUM_BANKS) |
                               tx_sch.invalid;
            ev[`CBT_EV_INVCTX] = st_nxt.sel.fault;
            st_nxt.sel.translate = st_r.trans_en & ~st_nxt.sel.fault;
            // stale TLB content never counts before invalidation
            st_nxt.sel.tlb_use = st_nxt.sel.translate & st_r.tlb_en &
                                 st_r.inv_done;
            st_nxt.sel.table_base_register_pair = tx_sch.table_base_register_pair;
            // hold off prefetch while the bank is being reconfigured
            st_nxt.sel.prefetch = st_nxt.sel.tlb_use &
                ~(bank_wr && wd.bank == TXN_BANK);
        end

        // a new event beats a clear in the same cycle
        st_nxt.irq_st = st_nxt.irq_st | ev;
        st_nxt.irq    = |(st_nxt.irq_st & st_nxt.irq_mask);
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            st_r <= ST_RST;
        else
            st_r <= st_nxt;
    end

    assign S_AXI_AWREADY = st_r.awready;
    assign S_AXI_WREADY  = st_r.wready;
    assign S_AXI_BVALID  = st_r.bvalid;
    assign S_AXI_BRESP   = st_r.bresp;
    assign S_AXI_ARREADY = st_r.arready;
    assign S_AXI_RVALID  = st_r.rvalid;
    assign S_AXI_RDATA   = st_r.rdata;
    assign S_AXI_RRESP   = st_r.rresp;
    assign SEL_VALID     = st_r.sel.valid;
    assign SEL_BANK      = st_r.sel.bank;
    assign SEL_BANK2     = st_r.sel.bank2;
    assign SEL_TWO       = st_r.sel.two;
    assign SEL_TRANSLATE = st_r.sel.translate;
    assign SEL_TLB_USE   = st_r.sel.tlb_use;
    assign SEL_TABLE_BASE_REGISTER_PAIR = st_r.sel.table_base_register_pair;
    assign SEL_FAULT     = st_r.sel.fault;
    assign PREFETCH_EN   = st_r.sel.prefetch;
    assign IRQ           = st_r.irq;

endmodule // cbt_top

// ### cbt_properties.sv
// Purpose: port properties of the context bank table control
// Assumes: one clock, RST_N asynchronous and active low
// Notes:   bound into every cbt_top instance
`timescale 1ns/1ps
module cbt_checker
(
    // clock and reset
    input wire logic       CLK,
    input wire logic       RST_N,
    // register write port
    input wire logic       S_AXI_AWVALID,
    input wire logic       S_AXI_AWREADY,
    input wire logic       S_AXI_WVALID,
    input wire logic       S_AXI_WREADY,
    input wire logic       S_AXI_BVALID,
    // bank selection
    input wire logic       TXN_VALID,
    input wire logic [6:0] TXN_BANK,
    input wire logic       TXN_TWO_STAGE,
    input wire logic [6:0] TXN_BANK2,
    input wire logic       SEL_VALID,
    input wire logic [6:0] SEL_BANK,
    input wire logic [6:0] SEL_BANK2,
    input wire logic       SEL_TWO,
    input wire logic       SEL_TRANSLATE,
    input wire logic       SEL_TLB_USE,
    input wire logic       SEL_FAULT,
    input wire logic       PREFETCH_EN
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_lat;
        TXN_VALID |=> SEL_VALID && SEL_BANK == $past(TXN_BANK);
    endproperty
    a_lat: assert property (p_lat)
        else $error("selection late or wrong bank");
    property p_idle;
        !TXN_VALID |=> !SEL_VALID && !SEL_FAULT && !PREFETCH_EN;
    endproperty
    a_idle: assert property (p_idle)
        else $error("selection output without request");
    property p_two;
        TXN_VALID |=> SEL_TWO == $past(TXN_TWO_STAGE) && SEL_BANK2 ==
            ($past(TXN_TWO_STAGE) ? $past(TXN_BANK2) : 7'h00);
    endproperty
    a_two: assert property (p_two)
        else $error("second bank wrong");
    property p_unimp;
        TXN_VALID && TXN_BANK > 7'h07 |=> SEL_FAULT && !SEL_TRANSLATE;
    endproperty
    a_unimp: assert property (p_unimp)
        else $error("missing bank not faulted");
    property p_tlb;
        SEL_TLB_USE |-> SEL_TRANSLATE && SEL_VALID;
    endproperty
    a_tlb: assert property (p_tlb)
        else $error("tlb used without translation");
    property p_pref;
        PREFETCH_EN |-> SEL_TLB_USE;
    endproperty
    a_pref: assert property (p_pref)
        else $error("prefetch without tlb use");
    property p_flt;
        SEL_FAULT |-> !SEL_TRANSLATE && !SEL_TLB_USE;
    endproperty
    a_flt: assert property (p_flt)
        else $error("faulted bank translates");
    property p_bresp;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
            |=> !S_AXI_AWREADY ##1 S_AXI_BVALID;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response late");
endmodule // cbt_checker
bind cbt_top cbt_checker chk_u (.*);

// ### cbt_txn_src.sv
// Purpose: upstream master asking for bank selection
// Assumes: one request per call, one cycle long
// Notes:   idle request lines show the inverse of the last value
`timescale 1ns/1ps
module cbt_txn_src
(
    // clock
    input wire logic   CLK,
    // request
    output logic       TXN_VALID,
    output logic       TXN_TWO_STAGE,
    output logic [6:0] TXN_BANK,
    output logic [6:0] TXN_BANK2
);
    initial
        {TXN_VALID, TXN_TWO_STAGE, TXN_BANK, TXN_BANK2} = '0;
    // secure bank 7 is asked for both before and after software typed it
    task automatic issue(input logic [6:0] b, input logic t,
                         input logic [6:0] b2);
        @(posedge CLK);
        {TXN_VALID, TXN_TWO_STAGE, TXN_BANK, TXN_BANK2} <= {1'b1, t, b, b2};
        @(posedge CLK);
        {TXN_VALID, TXN_TWO_STAGE, TXN_BANK, TXN_BANK2} <= {1'b0, ~t, ~b, ~b2};
    endtask
endmodule // cbt_txn_src

// ### tb_top.sv
// Purpose: self-checking bench of the context bank table control
// Assumes: 40 MHz clock, 4KB bank pages until the span is switched
// Notes:   expected values are worked out from the register map
`timescale 1ns/1ps
`include "cbt_defines.svh"
module tb_top;
    localparam logic [31:0] bb = `CBT_BANK_BASE;
    localparam logic [1:0]  ok = `CBT_RESP_OKAY;
    localparam logic [1:0]  se = `CBT_RESP_SLVERR;
    localparam logic [1:0]  de = `CBT_RESP_DECERR;
    logic CLK = 1'b0, RST_N = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
    logic S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic [31:0] S_AXI_AWADDR = '0, S_AXI_WDATA = '0, S_AXI_ARADDR = '0;
    logic [2:0]  S_AXI_AWPROT = '0, S_AXI_ARPROT = '0;
    logic [3:0]  S_AXI_WSTRB = '0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, IRQ;
    logic S_AXI_RVALID, SEL_VALID, SEL_TWO, SEL_TRANSLATE, SEL_TLB_USE;
    logic SEL_TABLE_BASE_REGISTER_PAIR, SEL_FAULT, PREFETCH_EN, TXN_VALID, TXN_TWO_STAGE;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    logic [31:0] S_AXI_RDATA;
    logic [6:0]  SEL_BANK, SEL_BANK2, TXN_BANK, TXN_BANK2;
    int mismatches = 0;
    int check_count = 0;
    cbt_top dut_u (.*);
    cbt_txn_src src_u (.*);
    always #12.5 CLK = ~CLK;
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, d, input logic ns,
                      input logic [1:0] er);
        bit ad = 1'b0;
        bit wd = 1'b0;
        @(posedge CLK);
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_WSTRB} <= {a, d, 4'hf};
        S_AXI_AWPROT <= {1'b0, ns, 1'b0};
        while (!(ad && wd))
        begin
            @(posedge CLK);
            ad = ad | S_AXI_AWREADY;
            wd = wd | S_AXI_WREADY;
            if (ad)
                S_AXI_AWVALID <= 1'b0;
            if (wd)
                S_AXI_WVALID <= 1'b0;
        end
        while (!S_AXI_BVALID)
            @(posedge CLK);
        S_AXI_BREADY <= 1'b0;
        chk("bresp", {30'h0, S_AXI_BRESP}, {30'h0, er});
    endtask
    task automatic rd(input logic [31:0] a, e, input logic ns,
                      input logic [1:0] er);
        @(posedge CLK);
        {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_ARADDR} <= {2'h3, a};
        S_AXI_ARPROT <= {1'b0, ns, 1'b0};
        @(posedge CLK);
        while (!S_AXI_ARREADY)
            @(posedge CLK);
        S_AXI_ARVALID <= 1'b0;
        @(posedge CLK);
        while (!S_AXI_RVALID)
            @(posedge CLK);
        S_AXI_RREADY <= 1'b0;
        chk("rresp", {30'h0, S_AXI_RRESP}, {30'h0, er});
        if (er == ok)
            chk("rdata", S_AXI_RDATA, e);
    endtask
    // expected vector: valid fault translate tlb prefetch pair two
    task automatic pick(input logic [6:0] b, input logic t,
                        input logic [6:0] b2, input logic [6:0] e);
        src_u.issue(b, t, b2);
        #1;
        chk("sel", {25'h0, SEL_VALID, SEL_FAULT, SEL_TRANSLATE, SEL_TLB_USE,
                    PREFETCH_EN, SEL_TABLE_BASE_REGISTER_PAIR, SEL_TWO}, {25'h0, e});
    endtask
    task automatic irq_is(input logic e);
        #1;
        chk("irq", {31'h0, IRQ}, {31'h0, e});
    endtask
    initial
    begin
        #100us;
        mismatches++;
        end_sim();
    end
    initial
    begin
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        rd(32'h0, 32'h4002_0008, 0, ok);
        rd(32'hc, 32'h0, 0, ok);
        pick(7'h3, 0, 7'h0, 7'b1000000);
        wr(32'h8, 32'h3, 0, ok);
        pick(7'h3, 0, 7'h0, 7'b1010000);
        rd(32'h10, 32'h4, 0, ok);
        wr(32'h14, 32'h4, 0, ok);
        irq_is(1);
        wr(32'h8, 32'h7, 0, ok);
        wr(32'h10, 32'h4, 0, ok);
        irq_is(0);
        rd(32'hc, 32'h3, 0, ok);
        pick(7'h3, 0, 7'h0, 7'b1011100);
        pick(7'h3, 1, 7'h5, 7'b1011101);
        // the bank write completes at the edge that takes the request
        fork
            wr(bb + 32'h3000, 32'h0, 0, ok);
            begin
                @(posedge CLK);
                pick(7'h3, 0, 7'h0, 7'b1011000);
            end
        join
        pick(7'h8, 0, 7'h0, 7'b1100010);
        wr(bb + 32'h1000, 32'h1, 0, ok);
        rd(bb + 32'h1000, 32'h0, 0, ok);
        wr(bb + 32'h2000, 32'h1, 0, ok);
        rd(bb + 32'h2008, 32'h2, 0, ok);
        wr(bb + 32'h2000, 32'h101, 0, ok);
        rd(bb + 32'h2008, 32'h0, 0, ok);
        wr(32'h4, 32'h6, 0, ok);
        rd(32'h0, 32'h4002_0006, 1, ok);
        rd(bb + 32'h7000, 32'h0, 1, se);
        rd(bb + 32'h7000, 32'h0, 0, ok);
        wr(32'h4, 32'h8, 1, ok);
        rd(32'h4, 32'h6, 0, ok);
        pick(7'h7, 0, 7'h0, 7'b1100010);
        wr(bb + 32'h7000, 32'h1, 0, ok);
        pick(7'h7, 0, 7'h0, 7'b1011110);
        rd(bb + 32'h7008, 32'ha, 0, ok);
        wr(bb + 32'h5004, 32'h1, 1, ok);
        wr(32'h4, 32'h5, 0, ok);
        rd(bb + 32'h5004, 32'h0, 0, ok);
        wr(32'h4, 32'h1, 0, ok);
        rd(32'h4, 32'h2, 0, ok);
        wr(32'h8, 32'hf, 0, ok);
        rd(bb + 32'h20000, 32'h101, 0, ok);
        rd(32'h0, 32'hc002_0008, 0, ok);
        rd(32'h18, 32'h0, 0, de);
        rd(bb + 32'h80000, 32'h0, 0, se);
        rd(bb + 32'h80_0000, 32'h0, 0, de);
        end_sim();
    end
endmodule // tb_top
